// ### rtl/fpc_pkg.sv
package fpc_pkg;

  localparam int NUM_LINES = 16;

  // register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_ACCESS = 8'h04;
  localparam logic [7:0] OFF_TAG    = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0C;
  localparam logic [7:0] OFF_WORD0  = 8'h10;
  localparam logic [7:0] OFF_WORD1  = 8'h14;
  localparam logic [7:0] OFF_WORD2  = 8'h18;
  localparam logic [7:0] OFF_WORD3  = 8'h1C;
  localparam logic [7:0] OFF_HIT    = 8'h20;
  localparam logic [7:0] OFF_MISS   = 8'h24;
  localparam logic [7:0] OFF_ABORT  = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;

  // field positions
  localparam int CFG_WS_LSB     = 0;
  localparam int CFG_PREDICTIVE_PREFETCH_ENABLE_BIT = 4;
  localparam int CFG_ALLOC_LSB  = 8;
  localparam int ACC_WEN_BIT    = 31;
  localparam int TAG_VALID_BIT  = 0;
  localparam int TAG_LOCK_BIT   = 1;
  localparam int TAG_ADDR_LSB   = 4;
  localparam int MASK_LSB       = 5;

  // program-data line allocation codes
  localparam logic [1:0] ALLOC_NONE = 2'h0;
  localparam logic [1:0] ALLOC_ONE  = 2'h1;
  localparam logic [1:0] ALLOC_TWO  = 2'h2;

  localparam logic [2:0] CCA_CACHEABLE = 3'h3;
  localparam logic [3:0] MASK_LINE_A   = 4'hA;
  localparam logic [3:0] MASK_LINE_B   = 4'hB;

  typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_PREFETCH, ST_PRELOAD} fpc_state_t;

  typedef struct packed {
    logic        valid;  // request held until ready
    logic        instr;  // 1 fetch, 0 load
    logic [2:0]  cca;    // cacheability attribute
    logic [19:0] addr;   // byte offset into program flash
  } fpc_cpu_req_t;

  typedef struct packed {
    logic        ready;
    logic [31:0] rdata;
  } fpc_cpu_rsp_t;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;   // 16-byte line address
  } fpc_flash_cmd_t;

  typedef struct packed {
    fpc_state_t             st;
    logic [2:0]             cnt;
    logic [19:0]            cur_addr;
    logic                   cur_instr;
    logic                   cur_cache;
    logic [15:0]            pf_line;
    logic [15:0][15:0]      tag;
    logic [15:0]            valid;
    logic [15:0]            lock;
    logic [10:0]            mask_a;
    logic [10:0]            mask_b;
    logic [15:0][127:0]     data;
    logic [3:0]             rr;
    logic [31:0]            hit_cnt;
    logic [31:0]            miss_cnt;
    logic [31:0]            abort_cnt;
    logic [1:0]             alloc;
    logic                   predictive_prefetch_enable;
    logic [2:0]             ws;
    logic                   acc_wen;
    logic [3:0]             acc_idx;
    logic                   preload_pend;
    logic                   preload_ack;
    logic [3:0]             preload_line;
    logic                   dph_wr;
    logic [7:0]             dph_addr;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    fpc_cpu_rsp_t           cpu_rsp;
    fpc_flash_cmd_t         flash;
  } fpc_regs_t;

endpackage

// ### rtl/fpc_cache_ctrl.sv
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// What this block does
// (RQ1) hit counter counts cacheable fetches and loads that hit; non-cacheable leave it
// (RQ2) miss counter counts cacheable instruction fetches that miss the cache
// (RQ3) abort counter counts prefetches dropped by non-sequential fetch or load
// (RQ4) allocation field reserves none, line 15, lines 14-15 or lines 12-15 for data
// (RQ5) prefetch enable fetches the next 16-byte aligned line ahead
// (RQ6) only accesses with cacheability attribute 3 fill the data array
// (RQ7) a line is locked against replacement only when valid and lock are both set
// (RQ8) writing tag with valid 0 and lock 1 raises a preload request
// (RQ9) preloads and tag accesses go to the line chosen by the line index
// (RQ10) tag writes are taken only while the tag write enable bit is set
// (RQ11) preload acknowledged the cycle after the write; prefetch stopped, processor stalled
// (RQ12) once the previous access ends, flash is read at the line's tag address
// (RQ13) after the wait states the line data is written and its valid bit set
// (RQ14) a preload leaves the replacement order unchanged
// (RQ15) stalled requests resume after the preload; a miss then takes a full flash access
// (RQ16) lines 10 and 11 apply their address mask to the tag compare
// (RQ17) masked hit answers at hit speed and, on an instruction fetch, starts the next-line prefetch when enabled
// (RQ18) mask covers aligned ranges from 32B spacing up to 32KB
// (RQ19) software must not let two lines match one address; set masks first
// (RQ20) manual fill: select line, set lock and valid, then write all four words
// (RQ21) software should lock one line or an aligned group of four
// (RQ22) cache word reads return data only when the part is not code-protected
// (RQ23) statistics counters wrap to zero and load software writes directly
module fpc_cache_ctrl (
  input  wire logic                    hclk,           // system clock
  input  wire logic                    hresetn,        // async reset, active low
  input  wire logic                    hsel,           // slave select
  input  wire logic [31:0]             haddr,          // byte address
  input  wire logic [1:0]              htrans,         // transfer type
  input  wire logic                    hwrite,         // write strobe
  input  wire logic [2:0]              hsize,          // word transfers only
  input  wire logic [31:0]             hwdata,         // write data
  input  wire logic                    hready,         // bus ready
  output logic                         hreadyout,      // always ready
  output logic                         hresp,          // always okay
  output logic [31:0]                  hrdata,         // read data
  input  wire fpc_pkg::fpc_cpu_req_t   cpu_req,        // processor fetch or load
  output fpc_pkg::fpc_cpu_rsp_t        cpu_rsp,        // processor answer
  output fpc_pkg::fpc_flash_cmd_t      flash_cmd,      // flash line read
  input  wire logic [127:0]            flash_rdata,    // flash line data
  input  wire logic                    code_protected, // blocks array reads
  output logic                         preload_ack     // one-cycle acknowledge
);

  fpc_pkg::fpc_regs_t r;
  fpc_pkg::fpc_regs_t n;

  logic        hit;
  logic [3:0]  hit_idx;
  logic        victim_ok;
  logic [3:0]  victim;
  logic        fill_instr;
  logic        pf_dup;
  logic        take;
  logic        cacheable;
  logic        aphase;
  logic [15:0] mword;
  logic [3:0]  cand;
  logic        data_line;
  logic        in_set;
  logic [31:0] rd;
  logic [1:0]  wsel;
  logic [127:0] fill_data;
  logic [15:0] fill_tag;
  logic        do_fill;

  assign hreadyout   = r.hreadyout;
  assign hresp       = 1'b0;
  assign hrdata      = r.hrdata;
  assign cpu_rsp     = r.cpu_rsp;
  assign flash_cmd   = r.flash;
  assign preload_ack = r.preload_ack;

  function automatic logic is_data_line(input logic [3:0] idx, input logic [1:0] alloc);
    logic res;
    res = 1'b0;
    unique case (alloc)
      fpc_pkg::ALLOC_NONE: res = 1'b0;
      fpc_pkg::ALLOC_ONE:  res = (idx == 4'hF);
      fpc_pkg::ALLOC_TWO:  res = (idx >= 4'hE);
      default:             res = (idx >= 4'hC);
    endcase
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n            = r;
    hit          = 1'b0;
    hit_idx      = 4'h0;
    victim_ok    = 1'b0;
    victim       = 4'h0;
    pf_dup       = 1'b0;
    mword        = 16'h0000;
    cand         = 4'h0;
    data_line    = 1'b0;
    in_set       = 1'b0;
    rd           = 32'h0000_0000;
    wsel         = 2'h0;
    fill_data    = flash_rdata;
    fill_tag     = r.cur_addr[19:4];
    do_fill      = 1'b0;
    fill_instr   = (r.st == fpc_pkg::ST_PREFETCH) ? 1'b1 : r.cur_instr;
    take         = cpu_req.valid && !r.cpu_rsp.ready;
    cacheable    = (cpu_req.cca == fpc_pkg::CCA_CACHEABLE);
    n.cpu_rsp.ready = 1'b0;
    n.preload_ack   = 1'b0;

    // lookup; masked bits compare equal on the two vector lines
    for (int i = 0; i < fpc_pkg::NUM_LINES; i++) begin
      if (4'(i) == fpc_pkg::MASK_LINE_A) begin
        mword = {4'h0, r.mask_a, 1'b0}; // RQ16 RQ18
      end else if (4'(i) == fpc_pkg::MASK_LINE_B) begin
        mword = {4'h0, r.mask_b, 1'b0}; // RQ16
      end else begin
        mword = 16'h0000;
      end
      if (!hit && r.valid[i] && (((cpu_req.addr[19:4] ^ r.tag[i]) & ~mword) == 16'h0000)) begin
        hit     = 1'b1;
        hit_idx = 4'(i);
      end
      if (r.valid[i] && (r.tag[i] == r.pf_line)) begin
        pf_dup = 1'b1;
      end
    end

    // victim: round robin from rr, skipping locked lines and honoring data allocation
    for (int k = 0; k < fpc_pkg::NUM_LINES; k++) begin
      cand      = r.rr + 4'(k);
      data_line = is_data_line(cand, r.alloc); // RQ4
      if (fill_instr) begin
        in_set = !data_line;
      end else begin
        in_set = (r.alloc == fpc_pkg::ALLOC_NONE) ? 1'b1 : data_line;
      end
      if (!victim_ok && in_set && !(r.valid[cand] && r.lock[cand])) begin // RQ7
        victim_ok = 1'b1;
        victim    = cand;
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    unique case (r.st)
      fpc_pkg::ST_IDLE: begin
        if (r.preload_pend) begin
          // processor requests simply wait here until the preload is done
          n.flash.req  = 1'b1; // RQ11 RQ12
          n.flash.addr = r.tag[r.preload_line]; // RQ9 RQ12
          n.cnt        = r.ws;
          n.st         = fpc_pkg::ST_PRELOAD;
        end else if (take) begin
          if (cacheable && hit) begin
            wsel              = cpu_req.addr[3:2];
            n.cpu_rsp.ready   = 1'b1; // RQ17
            n.cpu_rsp.rdata   = r.data[hit_idx][32*wsel +: 32];
            n.hit_cnt         = r.hit_cnt + 32'h0000_0001; // RQ1 RQ23
            if (r.predictive_prefetch_enable && cpu_req.instr) begin
              n.pf_line    = cpu_req.addr[19:4] + 16'h0001; // RQ5 RQ17
              n.flash.req  = 1'b1;
              n.flash.addr = cpu_req.addr[19:4] + 16'h0001;
              n.cnt        = r.ws;
              n.st         = fpc_pkg::ST_PREFETCH;
            end
          end else begin
            if (cacheable && cpu_req.instr) begin
              n.miss_cnt = r.miss_cnt + 32'h0000_0001; // RQ2 RQ23
            end
            n.cur_addr   = cpu_req.addr;
            n.cur_instr  = cpu_req.instr;
            n.cur_cache  = cacheable;
            n.flash.req  = 1'b1; // RQ15
            n.flash.addr = cpu_req.addr[19:4];
            n.cnt        = r.ws;
            n.st         = fpc_pkg::ST_FLASH;
          end
        end
      end
      fpc_pkg::ST_FLASH: begin
        if (r.cnt != 3'h0) begin
          n.cnt = r.cnt - 3'h1;
        end else begin
          wsel            = r.cur_addr[3:2];
          n.cpu_rsp.ready = 1'b1;
          n.cpu_rsp.rdata = flash_rdata[32*wsel +: 32];
          n.flash.req     = 1'b0;
          do_fill         = r.cur_cache; // RQ6
          n.st            = fpc_pkg::ST_IDLE;
          if (r.predictive_prefetch_enable && r.cur_cache && r.cur_instr) begin
            n.pf_line    = r.cur_addr[19:4] + 16'h0001; // RQ5
            n.flash.req  = 1'b1;
            n.flash.addr = r.cur_addr[19:4] + 16'h0001;
            n.cnt        = r.ws;
            n.st         = fpc_pkg::ST_PREFETCH;
          end
        end
      end
      fpc_pkg::ST_PREFETCH: begin
        if (r.preload_pend) begin
          // stopping a speculative read for a preload is not an abort
          n.flash.req = 1'b0; // RQ11
          n.st        = fpc_pkg::ST_IDLE;
        end else if (take && !(cpu_req.instr && cacheable &&
                               (cpu_req.addr[19:4] == r.pf_line))) begin
          n.abort_cnt = r.abort_cnt + 32'h0000_0001; // RQ3 RQ23
          n.flash.req = 1'b0;
          n.st        = fpc_pkg::ST_IDLE;
        end else if (r.cnt == 3'h0) begin
          n.flash.req = 1'b0;
          fill_tag    = r.pf_line;
          do_fill     = !pf_dup; // RQ6
          n.st        = fpc_pkg::ST_IDLE;
        end else begin
          n.cnt = r.cnt - 3'h1;
        end
      end
      fpc_pkg::ST_PRELOAD: begin
        if (r.cnt != 3'h0) begin
          n.cnt = r.cnt - 3'h1;
        end else begin
          // replacement pointer deliberately untouched
          n.data[r.preload_line]  = flash_rdata; // RQ13 RQ14
          n.valid[r.preload_line] = 1'b1; // RQ13
          n.preload_pend          = 1'b0; // RQ15
          n.flash.req             = 1'b0;
          n.st                    = fpc_pkg::ST_IDLE;
        end
      end
    endcase

    if (do_fill && victim_ok) begin
      n.data[victim]  = fill_data;
      n.tag[victim]   = fill_tag;
      n.valid[victim] = 1'b1;
      n.rr            = victim + 4'h1;
    end

    //////////////////////////////////////////////////////////////////////////////
    // bus address phase: read data prepared for the following data phase
    aphase = hsel && hready && htrans[1];
    n.dph_wr   = aphase && hwrite;
    n.dph_addr = haddr[7:0];
    if (aphase && !hwrite) begin
      unique case (haddr[7:0])
        fpc_pkg::OFF_CONFIG: begin
          rd[fpc_pkg::CFG_WS_LSB +: 3]    = r.ws;
          rd[fpc_pkg::CFG_PREDICTIVE_PREFETCH_ENABLE_BIT]     = r.predictive_prefetch_enable;
          rd[fpc_pkg::CFG_ALLOC_LSB +: 2] = r.alloc;
        end
        fpc_pkg::OFF_ACCESS: begin
          rd[fpc_pkg::ACC_WEN_BIT] = r.acc_wen;
          rd[3:0]                  = r.acc_idx;
        end
        fpc_pkg::OFF_TAG: begin
          rd[fpc_pkg::TAG_ADDR_LSB +: 16] = r.tag[r.acc_idx]; // RQ9
          rd[fpc_pkg::TAG_LOCK_BIT]       = r.lock[r.acc_idx];
          rd[fpc_pkg::TAG_VALID_BIT]      = r.valid[r.acc_idx];
        end
        fpc_pkg::OFF_MASK: begin
          if (r.acc_idx == fpc_pkg::MASK_LINE_A) begin
            rd[fpc_pkg::MASK_LSB +: 11] = r.mask_a;
          end else if (r.acc_idx == fpc_pkg::MASK_LINE_B) begin
            rd[fpc_pkg::MASK_LSB +: 11] = r.mask_b;
          end
        end
        fpc_pkg::OFF_WORD0: rd = code_protected ? 32'h0 : r.data[r.acc_idx][31:0];   // RQ22
        fpc_pkg::OFF_WORD1: rd = code_protected ? 32'h0 : r.data[r.acc_idx][63:32];  // RQ22
        fpc_pkg::OFF_WORD2: rd = code_protected ? 32'h0 : r.data[r.acc_idx][95:64];  // RQ22
        fpc_pkg::OFF_WORD3: rd = code_protected ? 32'h0 : r.data[r.acc_idx][127:96]; // RQ22
        fpc_pkg::OFF_HIT:    rd = r.hit_cnt;
        fpc_pkg::OFF_MISS:   rd = r.miss_cnt;
        fpc_pkg::OFF_ABORT:  rd = r.abort_cnt;
        fpc_pkg::OFF_STATUS: rd = {30'h0, r.st != fpc_pkg::ST_IDLE, r.preload_pend};
        default:             rd = 32'h0000_0000;
      endcase
      n.hrdata = rd;
    end

    // bus data phase: writes land after the hardware updates above
    if (r.dph_wr) begin
      unique case (r.dph_addr)
        fpc_pkg::OFF_CONFIG: begin
          n.ws     = hwdata[fpc_pkg::CFG_WS_LSB +: 3];
          n.predictive_prefetch_enable = hwdata[fpc_pkg::CFG_PREDICTIVE_PREFETCH_ENABLE_BIT];
          n.alloc  = hwdata[fpc_pkg::CFG_ALLOC_LSB +: 2];
        end
        fpc_pkg::OFF_ACCESS: begin
          n.acc_wen = hwdata[fpc_pkg::ACC_WEN_BIT];
          n.acc_idx = hwdata[3:0];
        end
        fpc_pkg::OFF_TAG: begin
          if (r.acc_wen) begin // RQ10
            n.tag[r.acc_idx]   = hwdata[fpc_pkg::TAG_ADDR_LSB +: 16]; // RQ9
            n.lock[r.acc_idx]  = hwdata[fpc_pkg::TAG_LOCK_BIT];
            n.valid[r.acc_idx] = hwdata[fpc_pkg::TAG_VALID_BIT];
            if (!hwdata[fpc_pkg::TAG_VALID_BIT] && hwdata[fpc_pkg::TAG_LOCK_BIT]) begin
              n.preload_pend = 1'b1; // RQ8
              n.preload_line = r.acc_idx; // RQ9
              n.preload_ack  = 1'b1; // RQ11
            end
          end
        end
        fpc_pkg::OFF_MASK: begin
          if (r.acc_wen && r.acc_idx == fpc_pkg::MASK_LINE_A) begin
            n.mask_a = hwdata[fpc_pkg::MASK_LSB +: 11]; // RQ16
          end else if (r.acc_wen && r.acc_idx == fpc_pkg::MASK_LINE_B) begin
            n.mask_b = hwdata[fpc_pkg::MASK_LSB +: 11]; // RQ16
          end
        end
        fpc_pkg::OFF_WORD0: n.data[r.acc_idx][31:0]   = hwdata;
        fpc_pkg::OFF_WORD1: n.data[r.acc_idx][63:32]  = hwdata;
        fpc_pkg::OFF_WORD2: n.data[r.acc_idx][95:64]  = hwdata;
        fpc_pkg::OFF_WORD3: n.data[r.acc_idx][127:96] = hwdata;
        fpc_pkg::OFF_HIT:   n.hit_cnt   = hwdata; // RQ23
        fpc_pkg::OFF_MISS:  n.miss_cnt  = hwdata; // RQ23
        fpc_pkg::OFF_ABORT: n.abort_cnt = hwdata; // RQ23
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r           <= '0;
      r.st        <= fpc_pkg::ST_IDLE;
      r.hreadyout <= 1'b1;
    end else begin
      r <= n;
    end
  end

endmodule

// ### bench/fpc_cache_ctrl_assertions.sv
`timescale 1ns/1ns
module fpc_chk (
  input wire logic                    hclk,           // clock
  input wire logic                    hresetn,        // reset
  input wire logic                    hsel,           // select
  input wire logic [31:0]             haddr,          // address
  input wire logic [1:0]              htrans,         // transfer
  input wire logic                    hwrite,         // write
  input wire logic [2:0]              hsize,          // size
  input wire logic [31:0]             hwdata,         // write data
  input wire logic                    hready,         // ready in
  input wire logic                    hreadyout,      // ready out
  input wire logic                    hresp,          // response
  input wire logic [31:0]             hrdata,         // read data
  input wire fpc_pkg::fpc_cpu_req_t   cpu_req,        // cpu request
  input wire fpc_pkg::fpc_cpu_rsp_t   cpu_rsp,        // cpu answer
  input wire fpc_pkg::fpc_flash_cmd_t flash_cmd,      // flash read
  input wire logic [127:0]            flash_rdata,    // flash data
  input wire logic                    code_protected, // protection
  input wire logic                    preload_ack     // acknowledge
);
  logic        rd_dph;
  logic        wr_dph;
  logic [7:0]  dph_addr;
  logic        dph_cp;
  logic        acc_wen;
  logic        cfg_pf;
  logic [15:0] pl_addr;
  ////////////////////////////////////////////////////////////////
  // shadow of the few register bits the properties depend on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dph   <= 1'b0;
      wr_dph   <= 1'b0;
      dph_addr <= 8'h00;
      dph_cp   <= 1'b0;
      acc_wen  <= 1'b0;
      cfg_pf   <= 1'b0;
      pl_addr  <= 16'h0000;
    end else begin
      rd_dph   <= hsel && hready && htrans[1] && !hwrite;
      wr_dph   <= hsel && hready && htrans[1] && hwrite;
      dph_addr <= haddr[7:0];
      dph_cp   <= code_protected;
      if (wr_dph && dph_addr == fpc_pkg::OFF_ACCESS) begin
        acc_wen <= hwdata[fpc_pkg::ACC_WEN_BIT];
      end
      if (wr_dph && dph_addr == fpc_pkg::OFF_CONFIG) begin
        cfg_pf <= hwdata[fpc_pkg::CFG_PREDICTIVE_PREFETCH_ENABLE_BIT];
      end
      if (wr_dph && dph_addr == fpc_pkg::OFF_TAG && acc_wen) begin
        pl_addr <= hwdata[19:4];
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_preload_wr;
    wr_dph && acc_wen && dph_addr == fpc_pkg::OFF_TAG && hwdata[1:0] == 2'h2;
  endsequence
  sequence s_nc_answer;
    cpu_rsp.ready && cpu_req.valid && cpu_req.cca != fpc_pkg::CCA_CACHEABLE;
  endsequence
  sequence s_preload_start;
    preload_ack ##1 (flash_cmd.req && flash_cmd.addr == pl_addr);
  endsequence
  AST_ACK_PULSE: assert property (s_preload_wr |=> preload_ack ##1 !preload_ack)
    else $error("preload acknowledge missing or too long");
  AST_ACK_CAUSE: assert property (
    preload_ack |-> $past(wr_dph && acc_wen && dph_addr == fpc_pkg::OFF_TAG))
    else $error("acknowledge without enabled tag write");
  AST_PRELOAD_READ: assert property (
    s_preload_wr |-> ##[1:20] (flash_cmd.req && flash_cmd.addr == pl_addr))
    else $error("preload flash read not at tag address");
  AST_STALL: assert property (
    s_preload_start |=> !cpu_rsp.ready)
    else $error("processor answered during preload");
  AST_RSP_CAUSE: assert property (
    cpu_rsp.ready |-> $past(cpu_req.valid) ##1 !cpu_rsp.ready)
    else $error("processor answer without request or too long");
  AST_NC_ADDR: assert property (
    s_nc_answer |-> $past(flash_cmd.req) && $past(flash_cmd.addr) == cpu_req.addr[19:4])
    else $error("non-cacheable access not read from flash");
  AST_NC_DATA: assert property (
    s_nc_answer |-> cpu_rsp.rdata == 32'($past(flash_rdata) >> {cpu_req.addr[3:2], 5'h00}))
    else $error("non-cacheable data differs from flash word");
  AST_WORD_PROTECT: assert property (
    rd_dph && dph_cp && dph_addr[7:4] == 4'h1 |-> hrdata == 32'h0)
    else $error("cache word readable while protected");
  AST_PF_NEXT: assert property (
    cfg_pf && cpu_rsp.ready && cpu_req.valid && cpu_req.instr
    && cpu_req.cca == fpc_pkg::CCA_CACHEABLE && $past(flash_cmd.req)
    && $past(flash_cmd.addr) == cpu_req.addr[19:4]
    |-> flash_cmd.req && flash_cmd.addr == cpu_req.addr[19:4] + 16'h1)
    else $error("next line not prefetched");
endmodule
bind fpc_cache_ctrl fpc_chk fpc_chk_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_req(cpu_req),
  .cpu_rsp(cpu_rsp), .flash_cmd(flash_cmd), .flash_rdata(flash_rdata),
  .code_protected(code_protected), .preload_ack(preload_ack)
);

// ### bench/fpc_flash_model.sv
`timescale 1ns/1ns
module fpc_flash_model (
  input  wire logic                    hclk,       // system clock
  input  wire fpc_pkg::fpc_flash_cmd_t flash_cmd,  // line read
  output logic [127:0]                 flash_rdata // line data
);
  // idle lines toggle so stale data is never mistaken for a read
  logic [127:0] junk = '0;
  always_ff @(posedge hclk) begin
    junk <= ~junk;
  end
  always_comb begin
    flash_rdata = junk;
    if (flash_cmd.req) begin
      for (int k = 0; k < 4; k++) begin
        flash_rdata[k*32 +: 32] = {8'h5A, 6'h00, k[1:0], flash_cmd.addr};
      end
    end
  end
endmodule

// ### bench/fpc_cache_ctrl_bench.sv
`timescale 1ns/1ns
module fpc_cache_ctrl_bench;
  logic                    hclk;
  logic                    hresetn;
  logic                    hsel;
  logic [31:0]             haddr;
  logic [1:0]              htrans;
  logic                    hwrite;
  logic [2:0]              hsize;
  logic [31:0]             hwdata;
  logic                    hreadyout;
  logic                    hresp;
  logic [31:0]             hrdata;
  fpc_pkg::fpc_cpu_req_t   cpu_req;
  fpc_pkg::fpc_cpu_rsp_t   cpu_rsp;
  fpc_pkg::fpc_flash_cmd_t flash_cmd;
  logic [127:0]            flash_rdata;
  logic                    code_protected;
  logic                    preload_ack;
  int                      n_errors;
  int                      comparisons;
  logic [31:0]             rd;
  int                      lat;
  fpc_cache_ctrl fpc_cache_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_req(cpu_req),
    .cpu_rsp(cpu_rsp), .flash_cmd(flash_cmd), .flash_rdata(flash_rdata),
    .code_protected(code_protected), .preload_ack(preload_ack)
  );
  fpc_flash_model fpc_flash_model_inst (
    .hclk(hclk), .flash_cmd(flash_cmd), .flash_rdata(flash_rdata)
  );
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] fw(input logic [19:0] a);
    return {8'h5A, 6'h00, a[3:2], a[19:4]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // l of zero skips the latency check
  task automatic cpu(input logic [19:0] a, input logic ins, input logic [2:0] c,
                     input logic [31:0] e, input int l);
    @(posedge hclk);
    cpu_req <= '{valid: 1'b1, instr: ins, cca: c, addr: a};
    lat = 0;
    do begin
      @(posedge hclk);
      lat++;
    end while (cpu_rsp.ready !== 1'b1);
    cpu_req.valid <= 1'b0;
    chk(cpu_rsp.rdata, e);
    if (l > 0) chk(lat, l);
  endtask
  task automatic close_out;
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    repeat (3000) @(posedge hclk);
    n_errors++;
    close_out;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cpu_req = '0;
    code_protected = 1'b0;
    n_errors = 0;
    comparisons = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 3; i++) rchk(fpc_pkg::OFF_HIT + 8'(4 * i), 32'h0);
    rchk(fpc_pkg::OFF_CONFIG, 32'h0);
    // non-cacheable never allocates, so both go to flash
    cpu(20'h00124, 1'b1, 3'h2, fw(20'h00124), 3);
    cpu(20'h00124, 1'b1, 3'h2, fw(20'h00124), 3);
    rchk(fpc_pkg::OFF_HIT, 32'h0);
    rchk(fpc_pkg::OFF_MISS, 32'h0);
    bus(1'b1, fpc_pkg::OFF_CONFIG, 32'h2);
    cpu(20'h00200, 1'b1, 3'h3, fw(20'h00200), 5);
    cpu(20'h0020C, 1'b1, 3'h3, fw(20'h0020C), 2);
    cpu(20'h00204, 1'b0, 3'h3, fw(20'h00204), 2);
    rchk(fpc_pkg::OFF_HIT, 32'h2);
    rchk(fpc_pkg::OFF_MISS, 32'h1);
    bus(1'b1, fpc_pkg::OFF_HIT, 32'hFFFFFFFF);
    cpu(20'h00208, 1'b1, 3'h3, fw(20'h00208), 2);
    rchk(fpc_pkg::OFF_HIT, 32'h0);
    // preload line 3 from flash line 0x030
    bus(1'b1, fpc_pkg::OFF_ACCESS, 32'h80000003);
    bus(1'b1, fpc_pkg::OFF_TAG, 32'h00000302);
    @(posedge hclk);
    chk({31'h0, preload_ack}, 32'h1);
    // fetch raised mid-preload must wait for the line, then hit
    cpu(20'h00304, 1'b1, 3'h3, fw(20'h00304), 4);
    rchk(fpc_pkg::OFF_TAG, 32'h00000303);
    for (int k = 0; k < 4; k++) rchk(fpc_pkg::OFF_WORD0 + 8'(4 * k), fw(20'h00300 + 20'(4 * k)));
    cpu(20'h00308, 1'b1, 3'h3, fw(20'h00308), 2);
    code_protected <= 1'b1;
    rchk(fpc_pkg::OFF_WORD1, 32'h0);
    code_protected <= 1'b0;
    // tag writes refused while the enable is clear
    bus(1'b1, fpc_pkg::OFF_ACCESS, 32'h00000003);
    bus(1'b1, fpc_pkg::OFF_TAG, 32'h00000502);
    @(posedge hclk);
    chk({31'h0, preload_ack}, 32'h0);
    rchk(fpc_pkg::OFF_TAG, 32'h00000303);
    // manual fill of masked line 10; a replica address must hit
    bus(1'b1, fpc_pkg::OFF_ACCESS, 32'h8000000A);
    bus(1'b1, fpc_pkg::OFF_TAG, 32'h00000403);
    bus(1'b1, fpc_pkg::OFF_MASK, 32'h000000E0);
    for (int k = 0; k < 4; k++) bus(1'b1, fpc_pkg::OFF_WORD0 + 8'(4 * k), 32'hC0DE0000 + k);
    cpu(20'h00464, 1'b1, 3'h3, 32'hC0DE0001, 2);
    rchk(fpc_pkg::OFF_MASK, 32'h000000E0);
    // prefetch with three wait states, then a load breaks it off
    bus(1'b1, fpc_pkg::OFF_CONFIG, 32'h00000013);
    cpu(20'h00800, 1'b1, 3'h3, fw(20'h00800), 6);
    cpu(20'h00A00, 1'b0, 3'h3, fw(20'h00A00), 0);
    rchk(fpc_pkg::OFF_ABORT, 32'h1);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, fpc_pkg::OFF_CONFIG, 32'(c) << 8);
      rchk(fpc_pkg::OFF_CONFIG, 32'(c) << 8);
    end
    close_out;
  end
endmodule
